// file: hdl/apop_port.sv
// Parallel output port of a 12-bit sampling converter with programmable done strobe.
`timescale 1ns/1ns
import apop_pkg::*;
module apop_port #(
	parameter int WIDTH = SAMPLE_WIDTH
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	input  wire logic                  sample_clock_in,
	input  wire logic                  sample_clock_complement_in,
	input  apop_pkg::apop_sample_t     sample_in,
	input  apop_pkg::apop_cfg_t        cfg_in,
	output logic [WIDTH-1:0]           sample_word_out,
	output logic                       in_range_flag_out,
	output logic                       conversion_done_strobe_out,
	output logic                       sample_word_oe_out
);
	import apop_pkg::*;

	logic [2:0]       cfg_sync;
	logic             clk_sync;
	logic             sample_clock_complement_sync;
	logic             clk_prev_r;
	logic             take_edge;
	apop_sample_t     stage_r [PIPE_DEPTH];
	logic [PIPE_DEPTH-1:0] stage_valid_r;
	logic             word_valid;
	logic [1:0]       delay_cnt_r;
	logic             delay_run_r;
	logic [3:0]       width_cnt_r;
	logic [11:0]      coded;
	logic             enabled;

	// Sample clock pair and static levels come from outside this clock's domain.
	apop_sync #(.WIDTH(5)) u_sync (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.async_in   ({sample_clock_in, sample_clock_complement_in, cfg_in.twos_complement_select,
			cfg_in.strobe_delay_sel_hi, cfg_in.strobe_delay_sel_lo}),
		.sync_out   ({clk_sync, sample_clock_complement_sync, cfg_sync})
	);

	// Chip enable is a static level, sampled directly; a glitch empties the pipeline and costs two words.
	assign enabled = ~cfg_in.chip_enable_n;

	// A sample is taken on a rising edge of the true clock while its complement is low.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			clk_prev_r <= 1'b0;
		else
			clk_prev_r <= clk_sync;
	end
	assign take_edge = clk_sync & ~clk_prev_r & ~sample_clock_complement_sync & enabled;

	// Fixed two-stage pipeline advanced once per sample clock edge.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (int i = 0; i < PIPE_DEPTH; i++)
				stage_r[i] <= '0;
			stage_valid_r <= '0;
		end
		else if (take_edge)
		begin
			stage_r[0]    <= sample_in;
			stage_valid_r <= {stage_valid_r[PIPE_DEPTH-2:0], 1'b1};
			for (int i = 1; i < PIPE_DEPTH; i++)
				stage_r[i] <= stage_r[i-1];
		end
		else if (!enabled)
			stage_valid_r <= '0;
	end
	assign word_valid = take_edge & stage_valid_r[PIPE_DEPTH-1];

	// Offset binary becomes two's complement by flipping the top bit.
	assign coded = cfg_sync[2] ? (stage_r[PIPE_DEPTH-1].code ^ MSB_FLIP) : stage_r[PIPE_DEPTH-1].code;

	// Output word and range flag update together so they stay aligned.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sample_word_out   <= WORD_RESET;
			in_range_flag_out <= 1'b0;
		end
		else if (word_valid)
		begin
			for (int b = LSB_POS; b <= MSB_POS; b++)
				sample_word_out[b] <= coded[b];
			in_range_flag_out <= stage_r[PIPE_DEPTH-1].in_range;
		end
	end

	// The sample word floats while disabled; the pad ring resolves the enable.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			sample_word_oe_out <= 1'b0;
		else
			sample_word_oe_out <= enabled;
	end

	// Strobe delay counts system cycles after each new word, set by the two selects.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			delay_cnt_r <= 2'h0;
			delay_run_r <= 1'b0;
		end
		else if (word_valid)
		begin
			delay_cnt_r <= cfg_sync[1:0];
			delay_run_r <= 1'b1;
		end
		else if (delay_run_r && delay_cnt_r != 2'h0)
			delay_cnt_r <= delay_cnt_r - 2'h1;
		else
			delay_run_r <= 1'b0;
	end

	// The strobe rises after the delay and holds long enough to be a clean capture edge.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			conversion_done_strobe_out <= 1'b0;
			width_cnt_r                <= 4'h0;
		end
		else if (delay_run_r && delay_cnt_r == 2'h0)
		begin
			conversion_done_strobe_out <= 1'b1;
			width_cnt_r                <= 4'(STROBE_WIDTH_CYC);
		end
		else if (width_cnt_r > 4'h1)
			width_cnt_r <= width_cnt_r - 4'h1;
		else
		begin
			conversion_done_strobe_out <= 1'b0;
			width_cnt_r                <= 4'h0;
		end
	end
endmodule : apop_port

// file: hdl/apop_pkg.sv
// Package with constants and carrier types for the converter parallel output port.
package apop_pkg;
	localparam int SAMPLE_WIDTH      = 12;
	localparam int PIPE_DEPTH        = 2;
	localparam int DELAY_SEL_WIDTH   = 2;
	localparam int MSB_POS           = 11;
	localparam int LSB_POS           = 0;
	localparam int SYNC_STAGES       = 3;
	localparam int MAX_RATE_MHZ      = 80;
	localparam int SYS_CLK_PERIOD_NS = 100;
	localparam int STROBE_WIDTH_NS   = 100;
	localparam int STROBE_WIDTH_CYC  = (STROBE_WIDTH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam logic [11:0] WORD_RESET  = 12'h000;
	localparam logic [11:0] MSB_FLIP    = 12'h800;

	// One converted sample as taken from the analog side.
	typedef struct packed {
		logic [11:0] code;
		logic        in_range;
	} apop_sample_t;

	// Static configuration levels driven by the outside party.
	typedef struct packed {
		logic twos_complement_select;
		logic strobe_delay_sel_hi;
		logic strobe_delay_sel_lo;
		logic chip_enable_n;
	} apop_cfg_t;
endpackage : apop_pkg

// file: hdl/apop_sync.sv
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/1ns
module apop_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             resetn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// Only the second stage reads the first; a change counts once stages two and three agree.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s1_r     <= '0;
			s2_r     <= '0;
			s3_r     <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < WIDTH; i++)
				if (s2_r[i] == s3_r[i])
					sync_out[i] <= s3_r[i];
		end
	end
endmodule : apop_sync

// file: bench/apop_port_asserts.sv
// Checker for the converter output port.
`timescale 1ns/1ns
module apop_port_asserts
	import apop_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input apop_cfg_t cfg_in,
	input wire logic [11:0] sample_word_out,
	input wire logic conversion_done_strobe_out,
	input wire logic sample_word_oe_out
);
	wire [1:0] sel = {cfg_in.strobe_delay_sel_hi, cfg_in.strobe_delay_sel_lo};
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// A new word while enabled starts the strobe delay.
	sequence s_upd;
		$changed(sample_word_out) && sample_word_oe_out;
	endsequence
	AST_STRB_W: assert property (conversion_done_strobe_out |=> !conversion_done_strobe_out)
		else $error("strobe wider than one cycle");
	AST_CE_OFF: assert property (cfg_in.chip_enable_n [*3] |-> !sample_word_oe_out)
		else $error("port driven while disabled");
	AST_CE_ON: assert property (!cfg_in.chip_enable_n [*3] |-> sample_word_oe_out)
		else $error("port idle while enabled");
	AST_QUIET: assert property (cfg_in.chip_enable_n [*8] |-> !conversion_done_strobe_out)
		else $error("strobe while disabled");
	// The strobe is sampled high one cycle plus the selected delay after the new word is seen.
	AST_DLY0: assert property (s_upd ##0 sel == 2'h0 |-> ##1 conversion_done_strobe_out)
		else $error("strobe delay 0 wrong");
	AST_DLY1: assert property (s_upd ##0 sel == 2'h1 |-> ##2 conversion_done_strobe_out)
		else $error("strobe delay 1 wrong");
	AST_DLY2: assert property (s_upd ##0 sel == 2'h2 |-> ##3 conversion_done_strobe_out)
		else $error("strobe delay 2 wrong");
	AST_DLY3: assert property (s_upd ##0 sel == 2'h3 |-> ##4 conversion_done_strobe_out)
		else $error("strobe delay 3 wrong");
endmodule : apop_port_asserts

// file: bench/apop_capture.sv
// Downstream capture logic clocked by the system clock, capturing on each rising edge of the done strobe.
`timescale 1ns/1ns
module apop_capture (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [11:0] word_in,
	input wire logic flag_in,
	input wire logic strobe_in,
	output logic got_out,
	output logic [12:0] data_out
);
	logic strobe_r;
	// Only the rising strobe edge captures, as a real capture clock would.
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			strobe_r <= 1'b0;
			got_out <= 1'b0;
			data_out <= 13'h0000;
		end
		else
		begin
			strobe_r <= strobe_in;
			got_out <= strobe_in && !strobe_r;
			if (strobe_in && !strobe_r)
				data_out <= {word_in, flag_in};
		end
	end
endmodule : apop_capture

// file: bench/testbench.sv
// Self-checking bench for the converter output port.
`timescale 1ns/1ns
module testbench;
	import apop_pkg::*;
	logic clk_sys_in = 0, resetn_in = 0, sck = 0, sckn = 1, got, flag, strb, oe;
	apop_sample_t smp = '0;
	apop_cfg_t cfg = 4'h1;
	logic [11:0] word;
	logic [12:0] cap;
	logic [12:0] expq[$];
	int n_errors = 0, checks = 0;
	apop_port apop_port_i (.clk_sys_in, .resetn_in, .sample_clock_in(sck), .sample_clock_complement_in(sckn),
		.sample_in(smp), .cfg_in(cfg), .sample_word_out(word), .in_range_flag_out(flag),
		.conversion_done_strobe_out(strb), .sample_word_oe_out(oe));
	apop_capture apop_capture_i (.clk_sys_in, .resetn_in, .word_in(word), .flag_in(flag),
		.strobe_in(strb), .got_out(got), .data_out(cap));
	initial forever #50 clk_sys_in = ~clk_sys_in;
	task check(input logic [12:0] seen, input logic [12:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task tally_and_finish;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// One 800 ns sample clock period; the expected word is noted as the sample is offered.
	task send;
		@(posedge clk_sys_in);
		#5 smp = {12'($urandom), 1'($urandom)};
		expq.push_back({smp.code ^ (cfg.twos_complement_select ? MSB_FLIP : 12'h000), smp.in_range});
		{sck, sckn} = 2'b10;
		repeat (4) @(posedge clk_sys_in);
		#5 {sck, sckn} = 2'b01;
		repeat (3) @(posedge clk_sys_in);
	endtask : send
	// Each capture retires the oldest note; an empty queue is a mismatch.
	always @(negedge clk_sys_in)
		if (got === 1'b1)
			check(cap, expq.size() ? expq.pop_front() : ~cap);
	// Every coding and delay mode, each entered through a disabled spell.
	initial
	begin
		void'($urandom(87));
		repeat (4) @(posedge clk_sys_in);
		#5 resetn_in = 1;
		for (int m = 0; m < 8; m++)
		begin
			repeat (8) @(posedge clk_sys_in);
			#5 cfg = {3'(m), 1'b1};
			repeat (30) @(posedge clk_sys_in);
			check(13'(expq.size()), m ? 13'h0002 : 13'h0000);
			expq.delete();
			#5 cfg.chip_enable_n = 1'b0;
			repeat (6) send();
			$display("mode %0d done", m);
		end
		tally_and_finish();
	end
	// Watchdog against a hung run.
	initial
	begin
		repeat (5000) @(posedge clk_sys_in);
		n_errors++;
		tally_and_finish();
	end
endmodule : testbench
bind apop_port apop_port_asserts apop_port_asserts_i (.clk_sys_in, .resetn_in, .cfg_in, .sample_word_out,
	.conversion_done_strobe_out, .sample_word_oe_out);
